// file: design/aoc_top.sv
// Converter control registers, Avalon-MM slave and calibration control
//
// How it works
// - Setting control-1 bit 6 arms offset calibration
// - Armed start runs calibration, stores measured offset
// - Later results subtract stored offset until replaced or cleared by reset
// - Calibration runs alone, compensates converter offset only
`timescale 1ns/100ps
module aoc_top
    import aoc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              ce_in,
    input  wire logic [AOC_AW-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire logic [11:0]       analog_code_in,
    output logic [3:0]             channel_select_out,
    output logic                   pos_reference_select_out,
    output logic                   neg_reference_select_out,
    output logic                   converter_on_out,
    output logic                   sampling_out,
    output logic                   cal_mode_out
);
    logic [7:0]  ctl0_q, ctl0_d;
    logic [7:0]  ctl1_q, ctl1_d;
    logic        go_q, go_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        req;
    logic        wr_ctl0, wr_ctl1;
    logic        start, abort;
    logic        busy, done, cal_done, cal_mode;
    logic [11:0] result;
    logic [7:0]  wbyte;

    aoc_engine u_engine (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .ce_in          (ce_in),
        .start_in       (start),
        .cal_in         (ctl1_q[AOC_BIT_CAL_ARM]),
        .abort_in       (abort),
        .analog_code_in (analog_code_in),
        .busy_out       (busy),
        .done_out       (done),
        .cal_done_out   (cal_done),
        .cal_mode_out   (cal_mode),
        .result_out     (result)
    );

    // One wait state: the first cycle of a request prepares read data
    assign req   = avs_read_in | avs_write_in;
    assign wbyte = avs_writedata_in[7:0];
    assign wr_ctl0 = ack_q & avs_write_in & avs_byteenable_in[0]
                   & (avs_address_in == AOC_ADDR_CTL0);
    assign wr_ctl1 = ack_q & avs_write_in & avs_byteenable_in[0]
                   & (avs_address_in == AOC_ADDR_CTL1);

    // A start only counts when the same write also sets the converter on
    // bit, and never while an operation is running
    assign start = wr_ctl0 & wbyte[AOC_BIT_GO] & wbyte[AOC_BIT_ON]
                 & ~go_q;
    // Switching the converter off ends any operation in progress
    assign abort = wr_ctl0 & ~wbyte[AOC_BIT_ON] & go_q;

    always_comb begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        if (req & ~ack_q) begin
            rdata_d = 32'h0000_0000;
            case (avs_address_in)
                AOC_ADDR_CTL0: begin
                    rdata_d[7:0] = ctl0_q;
                    rdata_d[AOC_BIT_GO] = go_q;
                end
                AOC_ADDR_CTL1: begin
                    rdata_d[7:0] = ctl1_q;
                end
                AOC_ADDR_RES_LO: begin
                    rdata_d[7:0] = result[7:0];
                end
                AOC_ADDR_RES_HI: begin
                    rdata_d[3:0] = result[11:8];
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_comb begin
        ctl0_d = ctl0_q;
        ctl1_d = ctl1_q;
        go_d   = go_q;
        if (wr_ctl0) begin
            ctl0_d = wbyte;
            ctl0_d[AOC_BIT_GO] = 1'b0;
        end
        // Hardware clears the start bit when the operation finishes
        if (done | abort) begin
            go_d = 1'b0;
        end
        if (start) begin
            go_d = 1'b1;
        end
        // Arm stays until the calibration cycle has completed; a new
        // arm written in the completing cycle wins over the clear
        if (cal_done) begin
            ctl1_d[AOC_BIT_CAL_ARM] = 1'b0;
        end
        if (wr_ctl1) begin
            ctl1_d = wbyte;
            if (cal_done & ~wbyte[AOC_BIT_CAL_ARM]) begin
                ctl1_d[AOC_BIT_CAL_ARM] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctl0_q  <= AOC_RST_CTL0;
            ctl1_q  <= AOC_RST_CTL1;
            go_q    <= 1'b0;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            ctl0_q  <= ctl0_d;
            ctl1_q  <= ctl1_d;
            go_q    <= go_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_out         = rdata_q;
    // Held while frozen, else a write would complete without landing
    assign avs_waitrequest_out      = req & ~(ack_q & ce_in);
    assign channel_select_out       = ctl0_q[AOC_CHS_HI:AOC_CHS_LO];
    assign pos_reference_select_out = ctl0_q[AOC_BIT_POS_REF];
    assign neg_reference_select_out = ctl0_q[AOC_BIT_NEG_REF];
    assign converter_on_out         = ctl0_q[AOC_BIT_ON];
    assign sampling_out             = busy;
    assign cal_mode_out             = cal_mode;
endmodule

// file: design/aoc_pkg.sv
// Package with register map, field positions and timing of the converter
package aoc_pkg;
    localparam int          AOC_AW            = 14;
    localparam logic [11:0] AOC_IDX_CTL0      = 12'hFC2;
    localparam logic [11:0] AOC_IDX_CTL1      = 12'hFC3;
    localparam logic [11:0] AOC_IDX_RES_LO    = 12'hFC4;
    localparam logic [11:0] AOC_IDX_RES_HI    = 12'hFC5;
    localparam logic [13:0] AOC_ADDR_CTL0     = {AOC_IDX_CTL0, 2'b00};
    localparam logic [13:0] AOC_ADDR_CTL1     = {AOC_IDX_CTL1, 2'b00};
    localparam logic [13:0] AOC_ADDR_RES_LO   = {AOC_IDX_RES_LO, 2'b00};
    localparam logic [13:0] AOC_ADDR_RES_HI   = {AOC_IDX_RES_HI, 2'b00};
    localparam int          AOC_BIT_NEG_REF   = 7;
    localparam int          AOC_BIT_POS_REF   = 6;
    localparam int          AOC_CHS_HI        = 5;
    localparam int          AOC_CHS_LO        = 2;
    localparam int          AOC_BIT_GO        = 1;
    localparam int          AOC_BIT_ON        = 0;
    localparam int          AOC_BIT_CAL_ARM   = 6;
    localparam logic [7:0]  AOC_RST_CTL0      = 8'h00;
    localparam logic [7:0]  AOC_RST_CTL1      = 8'h00;
    localparam logic [11:0] AOC_RST_OFFSET    = 12'h000;
    localparam int          AOC_CLK_PERIOD_NS = 50;
    localparam int          AOC_CONV_TIME_NS  = 800;
    localparam int          AOC_CONV_CYCLES   =
        (AOC_CONV_TIME_NS + AOC_CLK_PERIOD_NS - 1) / AOC_CLK_PERIOD_NS;
    localparam logic [7:0]  AOC_CONV_LAST     = 8'(AOC_CONV_CYCLES - 1);
    typedef enum logic {AOC_ENG_IDLE, AOC_ENG_RUN} aoc_eng_state_t;
endpackage

// file: design/aoc_engine.sv
// Conversion sequencer with offset storage and compensation
`timescale 1ns/100ps
module aoc_engine
    import aoc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        ce_in,
    input  wire logic        start_in,
    input  wire logic        cal_in,
    input  wire logic        abort_in,
    input  wire logic [11:0] analog_code_in,
    output logic             busy_out,
    output logic             done_out,
    output logic             cal_done_out,
    output logic             cal_mode_out,
    output logic [11:0]      result_out
);
    aoc_eng_state_t state_q, state_d;
    logic [7:0]     cnt_q, cnt_d;
    logic           cal_q, cal_d;
    logic [11:0]    offset_q, offset_d;
    logic [11:0]    result_q, result_d;
    logic           done_q, done_d;
    logic           cdone_q, cdone_d;

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        cal_d    = cal_q;
        offset_d = offset_q;
        result_d = result_q;
        done_d   = 1'b0;
        cdone_d  = 1'b0;
        case (state_q)
            AOC_ENG_IDLE: begin
                if (start_in) begin
                    state_d = AOC_ENG_RUN;
                    cnt_d   = 8'h00;
                    cal_d   = cal_in;
                end
            end
            AOC_ENG_RUN: begin
                if (abort_in) begin
                    state_d = AOC_ENG_IDLE;
                    cal_d   = 1'b0;
                end else if (cnt_q == AOC_CONV_LAST) begin
                    state_d = AOC_ENG_IDLE;
                    cal_d   = 1'b0;
                    done_d  = 1'b1;
                    if (cal_q) begin
                        // Front end has its inputs shorted, so the code is
                        // the converter's own offset only
                        offset_d = analog_code_in;
                        cdone_d  = 1'b1;
                    end else if (analog_code_in > offset_q) begin
                        result_d = analog_code_in - offset_q;
                    end else begin
                        // Clamp rather than wrap below zero
                        result_d = 12'h000;
                    end
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            default: begin
                state_d = AOC_ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q  <= AOC_ENG_IDLE;
            cnt_q    <= 8'h00;
            cal_q    <= 1'b0;
            offset_q <= AOC_RST_OFFSET;
            result_q <= 12'h000;
            done_q   <= 1'b0;
            cdone_q  <= 1'b0;
        end else if (ce_in) begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            cal_q    <= cal_d;
            offset_q <= offset_d;
            result_q <= result_d;
            done_q   <= done_d;
            cdone_q  <= cdone_d;
        end
    end

    assign busy_out     = (state_q == AOC_ENG_RUN);
    assign done_out     = done_q;
    assign cal_done_out = cdone_q;
    assign cal_mode_out = cal_q;
    assign result_out   = result_q;
endmodule

// file: test/aoc_top_checker.sv
// Checker of bus timing and conversion sequencing of the converter
`timescale 1ns/100ps
module aoc_top_checker
    import aoc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              ce_in,
    input  wire logic [AOC_AW-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic              avs_waitrequest_out,
    input  wire logic              converter_on_out,
    input  wire logic              sampling_out,
    input  wire logic              cal_mode_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in || !ce_in);
    logic       start_wr, abort_wr;
    logic [7:0] run_cnt;
    // Only an accepted start from idle counts; a start while busy is ignored
    assign start_wr = avs_write_in && !avs_waitrequest_out && !sampling_out
        && avs_byteenable_in[0] && avs_address_in == AOC_ADDR_CTL0
        && avs_writedata_in[1:0] == 2'h3;
    // Switching off during a run ends it early
    assign abort_wr = avs_write_in && !avs_waitrequest_out
        && avs_byteenable_in[0] && avs_address_in == AOC_ADDR_CTL0
        && !avs_writedata_in[0];
    // Cycles the current run has lasted, frozen together with the design
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            run_cnt <= 8'h00;
        end else if (ce_in) begin
            run_cnt <= sampling_out ? run_cnt + 8'h01 : 8'h00;
        end
    end
    AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer not after one wait state");
    // Start bit stays busy one cycle after a run, so such a start is refused
    AST_START_RUN: assert property (start_wr && !$past(sampling_out)
        |-> ##[1:2] sampling_out)
        else $error("accepted start did not begin a run");
    AST_RUN_LEN: assert property (
        sampling_out |-> run_cnt <= AOC_CONV_LAST)
        else $error("run longer than sixteen cycles");
    AST_RUN_FULL: assert property (
        $fell(sampling_out) && !$past(abort_wr)
        |-> $past(run_cnt) == AOC_CONV_LAST)
        else $error("run ended before sixteen cycles");
    AST_RUN_NEEDS_ON: assert property (sampling_out |-> converter_on_out)
        else $error("run while converter is off");
    AST_CAL_INSIDE: assert property (cal_mode_out |-> sampling_out)
        else $error("calibration outside a run");
    AST_CAL_AT_START: assert property (
        $rose(cal_mode_out) |-> $rose(sampling_out))
        else $error("calibration not started with the run");
endmodule

bind aoc_top aoc_top_checker aoc_top_checker_i (.clk_in, .nrst_in, .ce_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_waitrequest_out, .converter_on_out,
    .sampling_out, .cal_mode_out);

// file: test/aoc_top_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/100ps
module aoc_top_tb
    import aoc_pkg::*;
();
    logic        clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
    logic [13:0] avs_address_in = 14'h0000;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic [3:0]  avs_byteenable_in = 4'hF, channel_select_out;
    logic [11:0] analog_code_in = 12'h000, offs = 12'h000, res = 12'h000;
    logic        avs_waitrequest_out, pos_reference_select_out, sampling_out;
    logic        neg_reference_select_out, converter_on_out, cal_mode_out;
    logic [15:0] seed = 16'h003A;
    logic [13:0] addrs [5] = '{AOC_ADDR_CTL0, AOC_ADDR_CTL1, AOC_ADDR_RES_LO,
                               AOC_ADDR_RES_HI, 14'h0010};
    int          error_cnt = 0, n_tests = 0, cyc = 0, hold = 0;
    aoc_top aoc_top_i (.clk_in, .nrst_in, .ce_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out,
        .avs_waitrequest_out, .analog_code_in, .channel_select_out,
        .pos_reference_select_out, .neg_reference_select_out,
        .converter_on_out, .sampling_out, .cal_mode_out);
    initial forever #25 clk_in = ~clk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [11:0] comp(input logic [11:0] c,
                                         input logic [11:0] o);
        return (c > o) ? c - o : 12'h000;
    endfunction
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request stands until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [13:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= {24'h000000, d};
        do @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && ++n < 20);
        chk({31'h0, avs_waitrequest_out}, 32'h0);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic conv(input logic [7:0] cfg, input logic [11:0] code,
                        input logic cal);
        logic [7:0] c;
        int         n;
        c = (cfg & 8'hFC) | 8'h03;
        n = 0;
        analog_code_in <= code;
        acc(1'b1, AOC_ADDR_CTL0, c);
        // Clock enable low must freeze the run, not end it
        if (hold > 0) begin
            ce_in <= 1'b0;
            repeat (hold) @(posedge clk_in);
            chk({31'h0, sampling_out}, 32'h1);
            ce_in <= 1'b1;
        end
        acc(1'b0, AOC_ADDR_CTL0, 8'h00);
        chk(rd, {24'h0, c});
        do acc(1'b0, AOC_ADDR_CTL0, 8'h00); while (rd[1] !== 1'b0 && ++n < 20);
        chk(rd, {24'h0, c & 8'hFD});
        if (cal)
            offs = code;
        else
            res = comp(code, offs);
        acc(1'b0, AOC_ADDR_RES_LO, 8'h00);
        chk(rd, {24'h0, res[7:0]});
        acc(1'b0, AOC_ADDR_RES_HI, 8'h00);
        chk(rd, {28'h0, res[11:8]});
    endtask
    task automatic calib;
        acc(1'b1, AOC_ADDR_CTL1, 8'h40);
        acc(1'b0, AOC_ADDR_CTL1, 8'h00);
        chk(rd, 32'h00000040);
        seed = lfsr(seed);
        conv(seed[7:0], {4'h0, seed[15:8]}, 1'b1);
        acc(1'b0, AOC_ADDR_CTL1, 8'h00);
        chk(rd, 32'h00000000);
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        foreach (addrs[i]) begin
            acc(1'b0, addrs[i], 8'h00);
            chk(rd, 32'h0);
        end
        repeat (4) begin
            seed = lfsr(seed);
            acc(1'b1, AOC_ADDR_CTL0, seed[7:0] & 8'hFD);
            acc(1'b0, AOC_ADDR_CTL0, 8'h00);
            chk(rd, {24'h0, seed[7:0] & 8'hFD});
            chk({24'h0, neg_reference_select_out, pos_reference_select_out,
                 channel_select_out, 1'b0, converter_on_out},
                {24'h0, seed[7:0] & 8'hFD});
        end
        avs_byteenable_in <= 4'h0;
        acc(1'b1, AOC_ADDR_CTL0, 8'h00);
        avs_byteenable_in <= 4'hF;
        acc(1'b0, AOC_ADDR_CTL0, 8'h00);
        chk(rd, {24'h0, seed[7:0] & 8'hFD});
        acc(1'b1, AOC_ADDR_CTL0, 8'h02);
        acc(1'b0, AOC_ADDR_CTL0, 8'h00);
        chk(rd, 32'h0);
        repeat (2) begin
            seed = lfsr(seed);
            conv(seed[7:0], seed[15:4], 1'b0);
        end
        hold = 40;
        seed = lfsr(seed);
        conv(seed[7:0], seed[15:4], 1'b0);
        hold = 0;
        // Switching off mid-run ends it with the old result kept
        analog_code_in <= 12'h3C3;
        acc(1'b1, AOC_ADDR_CTL0, 8'h03);
        acc(1'b1, AOC_ADDR_CTL0, 8'h00);
        acc(1'b0, AOC_ADDR_CTL0, 8'h00);
        chk(rd, 32'h0);
        chk({31'h0, sampling_out}, 32'h0);
        acc(1'b0, AOC_ADDR_RES_LO, 8'h00);
        chk(rd, {24'h0, res[7:0]});
        calib;
        conv(8'h00, offs - 12'h001, 1'b0);
        conv(8'h00, offs, 1'b0);
        repeat (3) begin
            seed = lfsr(seed);
            conv(seed[7:0], seed[15:4], 1'b0);
        end
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        offs = 12'h000;
        res = 12'h000;
        conv(8'h00, 12'h0A5, 1'b0);
        calib;
        conv(8'h00, 12'hFFF, 1'b0);
        finish_test;
    end
endmodule
